// ===== rtl/tkpc_top.sv
// hundredths prescaler, square wave, ram wipe, interrupt b and bus inhibit
`timescale 1ns/1ps
// What this block does
// - divide 4096Hz by 41 for 24 periods, then 40 once, tick each period
// - 25-period sequence repeats forever, aligned every 250ms, 100Hz average
// - held low wipe input writes all ones into every user ram byte
// - wipe touches user ram bytes only, never time, alarm or watchdog
// - wipe acts only when input low while on backup with main supply absent
// - interrupt b follows polarity select: 1 sources high only above trip level, 0 sinks low
// - square wave driven in normal power, high impedance below trip level
// - below trip level on backup, ignore bus cycles and never drive data
// - divider and timekeeping keep running while bus access is inhibited
// - square wave control 0 gives 1024Hz output, 1 gives high impedance
// - polarity select is command bit 5, 1 sources, 0 sinks
module tkpc_top
    import tkpc_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       reset_n_i,
    input  wire logic       osc_4096_i,
    input  wire logic       power_fail_i,
    input  wire logic       backup_supply_in_i,
    input  wire logic       user_ram_wipe_n_i,
    input  wire logic       sqw_disable_i,
    input  wire logic       int_b_polarity_sel_i,
    input  wire logic       int_b_active_i,
    input  wire logic       bus_ce_n_i,
    input  wire logic       bus_oe_n_i,
    input  wire logic       bus_we_n_i,
    output logic            hundredths_tick_o,
    output logic            square_wave_out_o,
    output logic            square_wave_out_oe_o,
    output logic            interrupt_out_b_o,
    output logic            interrupt_out_b_oe_o,
    output logic            bus_read_en_o,
    output logic            bus_write_en_o,
    output logic            bus_data_lines_oe_o,
    output logic            user_ram_wipe_we_o,
    output logic [5:0]      user_ram_wipe_addr_o,
    output logic [7:0]      user_ram_wipe_data_o
);
    // ************************************************************
    // state registers
    // ************************************************************
    tkpc_state_t st_reg;
    tkpc_state_t st_next;
    logic        osc_rise;
    logic [5:0]  div_limit;
    logic        wipe_arm;
    logic        bus_ok;

    // agreed rising edge of the oscillator input
    assign osc_rise  = (st_reg.osc_sync[1] == st_reg.osc_sync[2]) && st_reg.osc_sync[1] && !st_reg.osc_level;
    assign div_limit = (st_reg.period_cnt == LONG_PERIODS) ? DIV_SHORT : DIV_LONG;
    assign wipe_arm  = !st_reg.wipe_n_level && st_reg.pf_level && st_reg.bat_level;
    assign bus_ok    = !st_reg.pf_level;

    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        // three-stage pin synchronisers
        st_next.osc_sync  = {st_reg.osc_sync[1:0], osc_4096_i};
        st_next.wipe_sync = {st_reg.wipe_sync[1:0], user_ram_wipe_n_i};
        st_next.pf_sync   = {st_reg.pf_sync[1:0], power_fail_i};
        st_next.bat_sync  = {st_reg.bat_sync[1:0], backup_supply_in_i};
        if (st_reg.osc_sync[1] == st_reg.osc_sync[2]) begin
            st_next.osc_level = st_reg.osc_sync[1];
        end
        if (st_reg.wipe_sync[1] == st_reg.wipe_sync[2]) begin
            st_next.wipe_n_level = st_reg.wipe_sync[1];
        end
        if (st_reg.pf_sync[1] == st_reg.pf_sync[2]) begin
            st_next.pf_level = st_reg.pf_sync[1];
        end
        if (st_reg.bat_sync[1] == st_reg.bat_sync[2]) begin
            st_next.bat_level = st_reg.bat_sync[1];
        end
        // fractional divider, advances only on oscillator edges
        if (osc_rise) begin
            st_next.sq_half = !st_reg.sq_half;
            if (st_reg.sq_half) begin
                st_next.sq_level = !st_reg.sq_level;
            end
            if (st_reg.div_cnt == div_limit - DIV_STEP) begin
                st_next.div_cnt = DIV_ZERO;
                st_next.tick    = 1'b1;
                if (st_reg.period_cnt == LONG_PERIODS) begin
                    st_next.period_cnt = PER_ZERO;
                end else begin
                    st_next.period_cnt = st_reg.period_cnt + PER_STEP;
                end
            end else begin
                st_next.div_cnt = st_reg.div_cnt + DIV_STEP;
            end
        end
        // user ram wipe walker
        st_next.wipe_we = wipe_arm;
        if (st_reg.wipe_we) begin
            if (st_reg.wipe_addr == USER_RAM_LAST) begin
                st_next.wipe_addr = USER_RAM_FIRST;
            end else begin
                st_next.wipe_addr = st_reg.wipe_addr + ADDR_STEP;
            end
        end
        if (!wipe_arm) begin
            st_next.wipe_addr = USER_RAM_FIRST;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_reg <= STATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign hundredths_tick_o    = st_reg.tick;
    assign square_wave_out_o    = st_reg.sq_level;
    assign square_wave_out_oe_o = !st_reg.pf_level && !sqw_disable_i;
    // b sinks low or sources high by polarity: drive the active level only while active
    assign interrupt_out_b_o    = int_b_polarity_sel_i;
    assign interrupt_out_b_oe_o = int_b_active_i && !(int_b_polarity_sel_i && st_reg.pf_level);
    assign bus_read_en_o        = bus_ok && !bus_ce_n_i && !bus_oe_n_i && bus_we_n_i;
    assign bus_write_en_o       = bus_ok && !bus_ce_n_i && !bus_we_n_i;
    assign bus_data_lines_oe_o  = bus_read_en_o;
    assign user_ram_wipe_we_o   = st_reg.wipe_we;
    assign user_ram_wipe_addr_o = st_reg.wipe_addr;
    assign user_ram_wipe_data_o = WIPE_DATA;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    property p_long_wrap;
        osc_rise && st_reg.period_cnt != LONG_PERIODS && st_reg.div_cnt == DIV_LONG - DIV_STEP
            |=> hundredths_tick_o && st_reg.div_cnt == DIV_ZERO;
    endproperty
    a_long_wrap: assert property (p_long_wrap) else $error("long period did not end at 41");

    property p_no_early_tick;
        hundredths_tick_o |-> $past(st_reg.div_cnt) == $past(div_limit) - DIV_STEP;
    endproperty
    a_no_early_tick: assert property (p_no_early_tick) else $error("tick at wrong count");

    property p_tick_single;
        hundredths_tick_o |=> !hundredths_tick_o;
    endproperty
    a_tick_single: assert property (p_tick_single) else $error("tick longer than one cycle");

    property p_short_period;
        hundredths_tick_o && st_reg.period_cnt == PER_ZERO |-> $past(st_reg.period_cnt) == LONG_PERIODS
            && $past(st_reg.div_cnt) == DIV_SHORT - DIV_STEP;
    endproperty
    a_short_period: assert property (p_short_period) else $error("sequence did not close with 40");

    property p_wipe_cond;
        user_ram_wipe_we_o |-> $past(wipe_arm);
    endproperty
    a_wipe_cond: assert property (p_wipe_cond) else $error("wipe outside backup or without input");

    property p_wipe_start;
        wipe_arm |=> user_ram_wipe_we_o && user_ram_wipe_data_o == WIPE_DATA;
    endproperty
    a_wipe_start: assert property (p_wipe_start) else $error("wipe did not start");

    property p_wipe_walk;
        user_ram_wipe_we_o && wipe_arm && user_ram_wipe_addr_o != USER_RAM_LAST
            |=> user_ram_wipe_we_o && user_ram_wipe_addr_o == $past(user_ram_wipe_addr_o) + ADDR_STEP;
    endproperty
    a_wipe_walk: assert property (p_wipe_walk) else $error("wipe address did not step");

    property p_wipe_stop;
        !wipe_arm |=> !user_ram_wipe_we_o && user_ram_wipe_addr_o == USER_RAM_FIRST;
    endproperty
    a_wipe_stop: assert property (p_wipe_stop) else $error("wipe went on without its condition");

    property p_wipe_range;
        user_ram_wipe_we_o |-> user_ram_wipe_addr_o >= USER_RAM_FIRST && user_ram_wipe_addr_o <= USER_RAM_LAST;
    endproperty
    a_wipe_range: assert property (p_wipe_range) else $error("wipe outside user ram");

    property p_interrupt_out_b_pol;
        !int_b_polarity_sel_i |-> (interrupt_out_b_oe_o == int_b_active_i) && !interrupt_out_b_o;
    endproperty
    a_interrupt_out_b_pol: assert property (p_interrupt_out_b_pol) else $error("interrupt b wrong level");

    property p_interrupt_out_b_high;
        int_b_polarity_sel_i && !st_reg.pf_level |-> (interrupt_out_b_oe_o == int_b_active_i) && interrupt_out_b_o;
    endproperty
    a_interrupt_out_b_high: assert property (p_interrupt_out_b_high) else $error("interrupt b active high wrong");

    property p_sqw_float;
        st_reg.pf_level || sqw_disable_i |-> !square_wave_out_oe_o;
    endproperty
    a_sqw_float: assert property (p_sqw_float) else $error("square wave driven while off");

    property p_bus_block;
        st_reg.pf_level |-> !bus_read_en_o && !bus_write_en_o && !bus_data_lines_oe_o;
    endproperty
    a_bus_block: assert property (p_bus_block) else $error("bus served below trip level");

    property p_run_in_fail;
        st_reg.pf_level && osc_rise |=> st_reg.div_cnt != $past(st_reg.div_cnt);
    endproperty
    a_run_in_fail: assert property (p_run_in_fail) else $error("divider stalled in power fail");

    property p_hold_stopped;
        !osc_rise |=> $stable(st_reg.div_cnt) && $stable(st_reg.period_cnt) && !hundredths_tick_o;
    endproperty
    a_hold_stopped: assert property (p_hold_stopped) else $error("divider moved without oscillator");

    c_short_tick: cover property (hundredths_tick_o && st_reg.period_cnt == PER_ZERO);
    c_wipe_wrap:  cover property (user_ram_wipe_we_o && user_ram_wipe_addr_o == USER_RAM_LAST);
    c_bus_read:   cover property (bus_data_lines_oe_o);
    c_sqw_toggle: cover property (square_wave_out_oe_o && $rose(square_wave_out_o));
endmodule : tkpc_top

// ===== rtl/tkpc_pkg.sv
// constants and state layout for the timekeeper prescaler and pin control
package tkpc_pkg;
    // ************************************************************
    // divider figures
    // ************************************************************
    localparam int unsigned OSC_HZ        = 4096;
    localparam int unsigned TICK_HZ       = 100;
    localparam int unsigned ALIGN_MS      = 250;
    localparam int unsigned ALIGN_PERIODS = ALIGN_MS * TICK_HZ / 1000;
    localparam logic [5:0]  DIV_LONG      = 6'h29;
    localparam logic [5:0]  DIV_SHORT     = 6'h28;
    localparam logic [4:0]  LONG_PERIODS  = 5'h18;
    localparam logic [5:0]  DIV_ZERO      = 6'h00;
    localparam logic [5:0]  DIV_STEP      = 6'h01;
    localparam logic [4:0]  PER_ZERO      = 5'h00;
    localparam logic [4:0]  PER_STEP      = 5'h01;

    // ************************************************************
    // user ram wipe range
    // ************************************************************
    localparam logic [5:0]  USER_RAM_FIRST = 6'h0e;
    localparam logic [5:0]  USER_RAM_LAST  = 6'h3f;
    localparam logic [5:0]  ADDR_STEP      = 6'h01;
    localparam logic [7:0]  WIPE_DATA      = 8'hff;

    // ************************************************************
    // state of the block
    // ************************************************************
    typedef struct packed {
        logic [2:0] osc_sync;
        logic       osc_level;
        logic [2:0] wipe_sync;
        logic       wipe_n_level;
        logic [2:0] pf_sync;
        logic       pf_level;
        logic [2:0] bat_sync;
        logic       bat_level;
        logic [5:0] div_cnt;
        logic [4:0] period_cnt;
        logic       tick;
        logic       sq_half;
        logic       sq_level;
        logic       wipe_we;
        logic [5:0] wipe_addr;
    } tkpc_state_t;

    localparam tkpc_state_t STATE_RESET = '{
        osc_sync: 3'h0, osc_level: 1'b0, wipe_sync: 3'h7, wipe_n_level: 1'b1,
        pf_sync: 3'h7, pf_level: 1'b1, bat_sync: 3'h0, bat_level: 1'b0,
        div_cnt: 6'h00, period_cnt: 5'h00, tick: 1'b0, sq_half: 1'b0,
        sq_level: 1'b0, wipe_we: 1'b0, wipe_addr: 6'h0e};
endpackage : tkpc_pkg

// ===== tb/tkpc_host_model.sv
// host strobe and oscillator model facing the block
`timescale 1ns/1ps
module tkpc_host_model
(
    input  wire logic       clk_sys_i,
    input  wire logic       osc_run_i,
    input  wire logic [1:0] cmd_i,
    output logic            osc_4096_o,
    output logic            bus_ce_n_o,
    output logic            bus_oe_n_o,
    output logic            bus_we_n_o
);
    logic [2:0] phase_reg = 3'h0;
    // oscillator stands still while stopped
    always @(posedge clk_sys_i) begin
        if (osc_run_i) begin
            phase_reg <= phase_reg + 3'h1;
        end
    end
    assign osc_4096_o = phase_reg[2];
    // 0 idle, 1 read, 2 write, 3 write with output enable low
    assign bus_ce_n_o = (cmd_i == 2'h0);
    assign bus_oe_n_o = !cmd_i[0];
    assign bus_we_n_o = !cmd_i[1];
endmodule : tkpc_host_model

// ===== tb/tb_top.sv
// self-checking bench for the prescaler and pin control
`timescale 1ns/1ps
module tb_top;
    import tkpc_pkg::*;
    logic clk_sys_i = 0, reset_n_i = 0, run = 1, pf = 0, bat = 0, wn = 1, sqd = 0, sel = 0, act = 0;
    logic [1:0] cmd = 2'h0;
    logic osc, ce_n, oe_n, we_n, tick, sq, sq_oe, ib, ib_oe, rd, wr, doe, w_we, osc_q = 0, sq_q = 0, w_ok = 0;
    logic [5:0] w_addr, e_addr = 6'h0e;
    logic [7:0] w_data;
    logic [31:0] seed = 32'd92177;
    int err_count = 0, total_checks = 0, ticks = 0, rises = 0, sq_r = 0, sq_seen = 0, w_cnt = 0, t0;
    // ************
    // clock, model, design
    // ************
    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    tkpc_host_model host (.clk_sys_i(clk_sys_i), .osc_run_i(run), .cmd_i(cmd), .osc_4096_o(osc),
        .bus_ce_n_o(ce_n), .bus_oe_n_o(oe_n), .bus_we_n_o(we_n));
    tkpc_top uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .osc_4096_i(osc), .power_fail_i(pf),
        .backup_supply_in_i(bat), .user_ram_wipe_n_i(wn), .sqw_disable_i(sqd), .int_b_polarity_sel_i(sel),
        .int_b_active_i(act), .bus_ce_n_i(ce_n), .bus_oe_n_i(oe_n), .bus_we_n_i(we_n),
        .hundredths_tick_o(tick), .square_wave_out_o(sq), .square_wave_out_oe_o(sq_oe),
        .interrupt_out_b_o(ib), .interrupt_out_b_oe_o(ib_oe), .bus_read_en_o(rd), .bus_write_en_o(wr),
        .bus_data_lines_oe_o(doe), .user_ram_wipe_we_o(w_we), .user_ram_wipe_addr_o(w_addr),
        .user_ram_wipe_data_o(w_data));
    // ************
    // helpers
    // ************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : step
    task automatic bus_phase(input int n);
        logic [31:0] r;
        for (int i = 0; i < n; i++) begin
            r = rnd();
            {sqd, act, sel, cmd} = r[4:0];
            for (int j = 0; j <= r[6:5]; j++) begin
                #1;
                chk(rd, cmd == 2'h1 && !pf);
                chk(wr, cmd[1] && !pf);
                chk(doe, cmd == 2'h1 && !pf);
                chk(sq_oe, !pf && !sqd);
                chk(ib, sel);
                chk(ib_oe, act && (!sel || !pf));
                step(1);
            end
        end
    endtask : bus_phase
    task automatic results();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results
    // ************
    // monitor of divider, square wave and wipe
    // ************
    always @(negedge clk_sys_i) begin
        if (reset_n_i) begin
            if (osc && !osc_q) begin
                rises++;
                sq_r++;
            end
            if (sq !== sq_q) begin
                if (sq_seen) chk(8'(sq_r), 8'h02);
                sq_seen = 1;
                sq_r = 0;
            end
            if (tick === 1'b1) begin
                if (ticks > 0) chk(8'(rises), (ticks % 25 == 24) ? 8'h28 : 8'h29);
                ticks++;
                rises = 0;
            end
            if (w_we === 1'b1) begin
                chk(w_addr, e_addr);
                chk(w_data, 8'hff);
                e_addr = (e_addr == 6'h3f) ? 6'h0e : e_addr + 6'h01;
                w_cnt++;
            end else begin
                e_addr = 6'h0e;
            end
            if (!w_ok) chk(w_we, 8'h00);
            osc_q = osc;
            sq_q = sq;
        end
    end
    initial begin
        #(20 * 60000);
        err_count++;
        results();
    end
    // ************
    // main sequence
    // ************
    initial begin
        step(10);
        reset_n_i = 1;
        step(5);
        bus_phase(300);
        pf = 1;
        step(5);
        bus_phase(300);
        bat = 1;
        wn = 0;
        pf = 0;
        step(30);
        bat = 0;
        pf = 1;
        step(30);
        w_ok = 1;
        bat = 1;
        step(130);
        wn = 1;
        step(6);
        w_ok = 0;
        chk(w_cnt >= 100, 8'h01);
        bat = 0;
        pf = 0;
        run = 0;
        step(8);
        t0 = ticks;
        step(600);
        chk(ticks == t0, 8'h01);
        run = 1;
        step(5);
        while (ticks < 60) bus_phase(10);
        results();
    end
endmodule : tb_top
